// ### src/temp_monitor_conversion_control.sv
`timescale 1ns/10ps
`include "temp_monitor_regs.svh"
// Summary of operation
// - config bit 7 high masks fault output
// - config bit 6 high selects software standby
// - reset clears mask and standby bits
// - only rate bits 2:0 are decoded
// - rate register resets to 02h
// - rate codes 0..7 give listed intervals
// - code 04h or below uses extended resolution
// - leaving standby while idle starts a conversion immediately
// - four limits, each channel compared after conversion
// - reading at or beyond limit flags fault
// - high limits reset 7fh, low c9h
// - remote compare uses integer byte only
// - send byte 0fh triggers single conversion
// - running: single command starts unless busy
// - standby: single command does one conversion
// - hardware sleep ignores single conversion command
// - single conversion clears fraction, basic mode
// - registers readable back through distinct codes
// - hardware sleep abandons conversion without update
// - status bit 7 shows converter busy
// - extended result splits eight plus three bits
module temp_monitor_conversion_control #(
	parameter int MS_CYCLES = `MS_CYCLES_DEFAULT
) (
	input wire logic core_clk_i,
	input wire logic resetn_i,
	input wire logic smb_clk_i,
	input wire logic cmd_valid_i,
	input wire temp_monitor_pkg::cmd_s cmd_i,
	input wire logic hw_sleep_n_i,
	input wire temp_monitor_pkg::reading_s reading_i,
	output logic cmd_busy_o,
	output logic cmd_done_o,
	output logic [7:0] rd_data_o,
	output logic conv_busy_o,
	output logic alert_n_o
);
	import temp_monitor_pkg::*;

	if (MS_CYCLES < 1) begin : g_check
		$error("MS_CYCLES must be at least one");
	end

	// link side: capture one command and hand it over by toggle
	logic link_pend;
	logic req_tgl;
	cmd_s link_cmd;
	logic ack_s1;
	logic ack_s2;
	logic ack_s3;
	logic [7:0] resp_data;
	logic ack_tgl;
	// one command in flight; a valid held past done would be taken again
	wire link_take = cmd_valid_i && !link_pend;
	wire link_ack = ack_s2 ^ ack_s3;

	always_ff @(posedge smb_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			link_pend <= 1'b0;
			req_tgl <= 1'b0;
			link_cmd <= '0;
		end else if (link_take) begin
			link_pend <= 1'b1;
			req_tgl <= ~req_tgl;
			link_cmd <= cmd_i;
		end else if (link_ack) begin
			link_pend <= 1'b0;
		end
	end

	always_ff @(posedge smb_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ack_s1 <= 1'b0;
			ack_s2 <= 1'b0;
			ack_s3 <= 1'b0;
			cmd_done_o <= 1'b0;
			rd_data_o <= 8'h00;
			cmd_busy_o <= 1'b0;
		end else begin
			ack_s1 <= ack_tgl;
			ack_s2 <= ack_s1;
			ack_s3 <= ack_s2;
			cmd_done_o <= link_ack;
			cmd_busy_o <= link_take || (link_pend && !link_ack);
			if (link_ack) begin
				rd_data_o <= resp_data;
			end
		end
	end

	// core side synchronisers
	// the sleep pin and readings are asynchronous; two stages settle them
	logic req_s1;
	logic req_s2;
	logic req_s3;
	logic sleep_s1;
	logic sleep_s2;
	reading_s rd_s1;
	reading_s rd_s2;

	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			req_s1 <= 1'b0;
			req_s2 <= 1'b0;
			req_s3 <= 1'b0;
			sleep_s1 <= 1'b0;
			sleep_s2 <= 1'b0;
			rd_s1 <= '0;
			rd_s2 <= '0;
		end else begin
			req_s1 <= req_tgl;
			req_s2 <= req_s1;
			req_s3 <= req_s2;
			sleep_s1 <= hw_sleep_n_i;
			sleep_s2 <= sleep_s1;
			rd_s1 <= reading_i;
			rd_s2 <= rd_s1;
		end
	end

	// command decode; link_cmd is stable while the request is pending
	wire req_new = req_s2 ^ req_s3;
	wire is_wr = req_new && link_cmd.write;
	wire is_send = req_new && !link_cmd.write;
	wire wr_config = is_wr && link_cmd.code == `CMD_CONFIG_WRITE;
	wire wr_rate = is_wr && link_cmd.code == `CMD_RATE_WRITE;
	wire wr_lh = is_wr && link_cmd.code == `CMD_LOCAL_HIGH_WRITE;
	wire wr_ll = is_wr && link_cmd.code == `CMD_LOCAL_LOW_WRITE;
	wire wr_rh = is_wr && link_cmd.code == `CMD_REMOTE_HIGH_WRITE;
	wire wr_rl = is_wr && link_cmd.code == `CMD_REMOTE_LOW_WRITE;
	wire cmd_single = is_send && link_cmd.code == `CMD_SINGLE_CONVERSION;
	wire cmd_alert_ack = is_send && link_cmd.code == `CMD_ALERT_ACK;
	wire rd_status = is_send && link_cmd.code == `CMD_STATUS_READ;

	logic [7:0] config_control;
	logic [7:0] conversion_rate_code;
	logic [7:0] local_high_limit;
	logic [7:0] local_low_limit;
	logic [7:0] remote_high_limit;
	logic [7:0] remote_low_limit;
	logic [7:0] local_reading;
	logic [7:0] remote_integer_reading;
	logic [7:0] remote_fraction_reading;
	logic [3:0] flags;
	logic alert_latch;
	conv_state_e state;
	logic conv_basic;
	logic [31:0] ms_cnt;
	logic [14:0] interval_ms;
	logic [14:0] conv_ms;

	wire sleeping = !sleep_s2;
	wire standby = config_control[`CFG_STANDBY_BIT];
	wire mask_on = config_control[`CFG_MASK_BIT];
	wire running = !standby && !sleeping;
	wire ms_tick = ms_cnt == MS_CYCLES - 1;
	// reserved codes 08h and up alias onto the low bits, so scheduling never stops
	wire [2:0] rate_sel = conversion_rate_code[`RATE_CODE_MSB:0];
	wire ext_mode = rate_sel <= `RATE_EXT_MAX;
	// leaving standby mid-conversion lets that conversion finish rather than restart
	wire leave_standby = wr_config && standby && !link_cmd.data[`CFG_STANDBY_BIT] && !sleeping;

	// interval per decoded code
	logic [14:0] interval_sel;
	always_comb begin
		case (rate_sel)
			3'h0: interval_sel = `INTERVAL_R0_MS;
			3'h1: interval_sel = `INTERVAL_R1_MS;
			3'h2: interval_sel = `INTERVAL_R2_MS;
			3'h3: interval_sel = `INTERVAL_R3_MS;
			3'h4: interval_sel = `INTERVAL_R4_MS;
			3'h5: interval_sel = `INTERVAL_R5_MS;
			3'h6: interval_sel = `INTERVAL_R6_MS;
			default: interval_sel = `INTERVAL_R7_MS;
		endcase
	end

	wire idle = state == CONV_IDLE;
	wire auto_start = running && idle && interval_ms == 15'd0 && ms_tick;
	wire single_start = cmd_single && !sleeping && idle;
	wire start_any = auto_start || single_start || (leave_standby && idle);
	wire conv_basic_next = single_start || !ext_mode;
	wire [14:0] conv_len = conv_basic_next ? `CONV_BASIC_MS : `CONV_EXT_MS;
	wire conv_end = !idle && !sleeping && ms_tick && conv_ms == 15'd0;
	// hardware sleep drops a conversion before conv_end can store its results
	wire abandon = !idle && sleeping;

	// conversion result and limit checks
	wire [7:0] rem_int = rd_s2.remote_t[`REM_INT_MSB:`REM_INT_LSB];
	wire [7:0] rem_frac = conv_basic ? 8'h00 : {rd_s2.remote_t[`REM_FRAC_MSB:0], 5'h00};
	wire hit_lh = $signed(rd_s2.local_t) >= $signed(local_high_limit);
	wire hit_ll = $signed(rd_s2.local_t) <= $signed(local_low_limit);
	wire hit_rh = $signed(rem_int) >= $signed(remote_high_limit);
	wire hit_rl = $signed(rem_int) <= $signed(remote_low_limit);
	wire [3:0] hits = {hit_lh, hit_ll, hit_rh, hit_rl};
	wire [3:0] new_hits = conv_end ? hits : 4'h0;
	// status bits 2:0 stay zero; diode faults are not modelled here
	wire [7:0] status_val = {!idle, flags, 3'h0};
	wire alert_now = alert_latch || |new_hits;

	// write codes and unknown codes read back as zero
	logic [7:0] read_mux;
	always_comb begin
		case (link_cmd.code)
			`CMD_LOCAL_READ: read_mux = local_reading;
			`CMD_REMOTE_INT_READ: read_mux = remote_integer_reading;
			`CMD_REMOTE_FRAC_READ: read_mux = remote_fraction_reading;
			`CMD_STATUS_READ: read_mux = status_val;
			`CMD_CONFIG_READ: read_mux = config_control;
			`CMD_RATE_READ: read_mux = conversion_rate_code;
			`CMD_LOCAL_HIGH_READ: read_mux = local_high_limit;
			`CMD_LOCAL_LOW_READ: read_mux = local_low_limit;
			`CMD_REMOTE_HIGH_READ: read_mux = remote_high_limit;
			`CMD_REMOTE_LOW_READ: read_mux = remote_low_limit;
			default: read_mux = 8'h00;
		endcase
	end

	// register file
	// reserved configuration and rate bits are kept and read back as written
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			config_control <= `CONFIG_RESET;
			conversion_rate_code <= `RATE_RESET;
			local_high_limit <= `HIGH_LIMIT_RESET;
			local_low_limit <= `LOW_LIMIT_RESET;
			remote_high_limit <= `HIGH_LIMIT_RESET;
			remote_low_limit <= `LOW_LIMIT_RESET;
		end else begin
			if (wr_config) begin
				config_control <= link_cmd.data;
			end
			if (wr_rate) begin
				conversion_rate_code <= link_cmd.data;
			end
			if (wr_lh) begin
				local_high_limit <= link_cmd.data;
			end
			if (wr_ll) begin
				local_low_limit <= link_cmd.data;
			end
			if (wr_rh) begin
				remote_high_limit <= link_cmd.data;
			end
			if (wr_rl) begin
				remote_low_limit <= link_cmd.data;
			end
		end
	end

	// response handshake back to the link side
	// resp_data settles a full link cycle before ack_tgl is seen there
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			resp_data <= 8'h00;
			ack_tgl <= 1'b0;
		end else if (req_new) begin
			resp_data <= read_mux;
			ack_tgl <= ~ack_tgl;
		end
	end

	// millisecond timebase
	// durations count whole ticks, so each may run up to one tick longer
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ms_cnt <= 32'h0;
		end else begin
			ms_cnt <= ms_tick ? 32'h0 : ms_cnt + 32'h1;
		end
	end

	// conversion scheduler
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state <= CONV_IDLE;
			conv_basic <= 1'b0;
			conv_ms <= 15'd0;
			interval_ms <= 15'd0;
		end else begin
			// the interval runs from every start, a single command included
			if (start_any) begin
				interval_ms <= interval_sel;
			end else if (ms_tick && interval_ms != 15'd0) begin
				interval_ms <= interval_ms - 15'd1;
			end
			case (state)
				CONV_IDLE: begin
					if (start_any) begin
						state <= CONV_RUNNING;
						conv_basic <= conv_basic_next;
						conv_ms <= conv_len;
					end
				end
				CONV_RUNNING: begin
					if (abandon || conv_end) begin
						state <= CONV_IDLE;
					end else if (ms_tick) begin
						conv_ms <= conv_ms - 15'd1;
					end
				end
				default: state <= CONV_IDLE;
			endcase
		end
	end

	// results, sticky flags and fault output
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			local_reading <= 8'h00;
			remote_integer_reading <= 8'h00;
			remote_fraction_reading <= 8'h00;
			flags <= 4'h0;
			alert_latch <= 1'b0;
			alert_n_o <= 1'b1;
			conv_busy_o <= 1'b0;
		end else begin
			// results land only at conv_end; an abandoned conversion leaves them alone
			if (conv_end) begin
				local_reading <= rd_s2.local_t;
				remote_integer_reading <= rem_int;
				remote_fraction_reading <= rem_frac;
			end
			// a new hit wins over the clear of a status read
			flags <= (rd_status ? 4'h0 : flags) | new_hits;
			// a new hit also wins over the alert acknowledge
			if (|new_hits) begin
				alert_latch <= 1'b1;
			end else if (cmd_alert_ack) begin
				alert_latch <= 1'b0;
			end
			alert_n_o <= !(alert_now && !mask_on);
			conv_busy_o <= !idle && !abandon && !conv_end;
		end
	end

endmodule : temp_monitor_conversion_control

// ### src/temp_monitor_regs.svh
`ifndef TEMP_MONITOR_REGS_SVH
`define TEMP_MONITOR_REGS_SVH

// command codes on the register port
`define CMD_LOCAL_READ 8'h00
`define CMD_REMOTE_INT_READ 8'h01
`define CMD_STATUS_READ 8'h02
`define CMD_CONFIG_READ 8'h03
`define CMD_RATE_READ 8'h04
`define CMD_LOCAL_HIGH_READ 8'h05
`define CMD_LOCAL_LOW_READ 8'h06
`define CMD_REMOTE_HIGH_READ 8'h07
`define CMD_REMOTE_LOW_READ 8'h08
`define CMD_CONFIG_WRITE 8'h09
`define CMD_RATE_WRITE 8'h0a
`define CMD_LOCAL_HIGH_WRITE 8'h0b
`define CMD_LOCAL_LOW_WRITE 8'h0c
`define CMD_REMOTE_HIGH_WRITE 8'h0d
`define CMD_REMOTE_LOW_WRITE 8'h0e
`define CMD_SINGLE_CONVERSION 8'h0f
`define CMD_REMOTE_FRAC_READ 8'h10
`define CMD_ALERT_ACK 8'h11

// field positions
`define CFG_MASK_BIT 7
`define CFG_STANDBY_BIT 6
`define STAT_BUSY_BIT 7
`define RATE_EXT_MAX 3'h4
`define RATE_FASTEST 3'h7
`define RATE_CODE_MSB 2
`define REM_INT_MSB 10
`define REM_INT_LSB 3
`define REM_FRAC_MSB 2

// reset values
`define CONFIG_RESET 8'h00
`define RATE_RESET 8'h02
`define HIGH_LIMIT_RESET 8'h7f
`define LOW_LIMIT_RESET 8'hc9

// timing in milliseconds, core clock in MHz and cycles per millisecond
`define INTERVAL_R0_MS 15'd16667
`define INTERVAL_R1_MS 15'd8333
`define INTERVAL_R2_MS 15'd4545
`define INTERVAL_R3_MS 15'd2500
`define INTERVAL_R4_MS 15'd1429
`define INTERVAL_R5_MS 15'd500
`define INTERVAL_R6_MS 15'd250
`define INTERVAL_R7_MS 15'd125
`define CONV_EXT_MS 15'd700
`define CONV_BASIC_MS 15'd100
`define CORE_CLK_MHZ 250
`define MS_CYCLES_DEFAULT (`CORE_CLK_MHZ * 1000)

`endif

// ### src/temp_monitor_pkg.sv
package temp_monitor_pkg;

	typedef enum logic [0:0] {
		CONV_IDLE,
		CONV_RUNNING
	} conv_state_e;

	typedef struct packed {
		logic write;
		logic [7:0] code;
		logic [7:0] data;
	} cmd_s;

	typedef struct packed {
		logic [7:0] local_t;
		logic [10:0] remote_t;
	} reading_s;

endpackage : temp_monitor_pkg

// ### testbench/temp_monitor_sva.sv
`timescale 1ns/10ps
module temp_monitor_sva
	import temp_monitor_pkg::*;
#(
	parameter int MS_CYCLES = 10
) (
	input wire logic core_clk_i,
	input wire logic resetn_i,
	input wire logic smb_clk_i,
	input wire logic cmd_valid_i,
	input wire temp_monitor_pkg::cmd_s cmd_i,
	input wire logic hw_sleep_n_i,
	input wire temp_monitor_pkg::reading_s reading_i,
	input wire logic cmd_busy_o,
	input wire logic cmd_done_o,
	input wire logic [7:0] rd_data_o,
	input wire logic conv_busy_o,
	input wire logic alert_n_o
);
	int busy_len;
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			busy_len <= 0;
		end else begin
			busy_len <= conv_busy_o ? busy_len + 1 : 0;
		end
	end
	sequence sleep_held;
		!hw_sleep_n_i [*6];
	endsequence
	sequence taken;
		cmd_valid_i && !cmd_busy_o && !cmd_done_o;
	endsequence
	done_pulse_a: assert property (@(posedge smb_clk_i) disable iff (!resetn_i)
		cmd_done_o |=> !cmd_done_o) else $error("done longer than one cycle");
	take_busy_a: assert property (@(posedge smb_clk_i) disable iff (!resetn_i)
		taken |=> cmd_busy_o) else $error("command not taken");
	answer_bound_a: assert property (@(posedge smb_clk_i) disable iff (!resetn_i)
		$rose(cmd_busy_o) |-> ##[1:12] cmd_done_o) else $error("no answer");
	done_after_busy_a: assert property (@(posedge smb_clk_i) disable iff (!resetn_i)
		cmd_done_o |-> !cmd_busy_o && $past(cmd_busy_o)) else $error("done without busy");
	read_hold_a: assert property (@(posedge smb_clk_i) disable iff (!resetn_i)
		!cmd_done_o |-> $stable(rd_data_o)) else $error("read data moved");
	sleep_abort_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
		sleep_held |-> !conv_busy_o) else $error("converting in sleep");
	sleep_quiet_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
		sleep_held |=> $stable(conv_busy_o)) else $error("conversion started in sleep");
	conv_min_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
		$fell(conv_busy_o) && hw_sleep_n_i |-> busy_len >= 98 * MS_CYCLES)
		else $error("conversion too short");
	conv_max_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
		conv_busy_o |-> busy_len <= 702 * MS_CYCLES) else $error("conversion too long");
endmodule : temp_monitor_sva

bind temp_monitor_conversion_control temp_monitor_sva #(.MS_CYCLES(MS_CYCLES)) sva_i (
	.core_clk_i, .resetn_i, .smb_clk_i, .cmd_valid_i, .cmd_i, .hw_sleep_n_i, .reading_i,
	.cmd_busy_o, .cmd_done_o, .rd_data_o, .conv_busy_o, .alert_n_o);

// ### testbench/smb_host_model.sv
`timescale 1ns/10ps
module smb_host_model
	import temp_monitor_pkg::*;
(
	input wire logic resetn_i,
	input wire logic start_i,
	input wire temp_monitor_pkg::cmd_s cmd_i,
	input wire logic cmd_busy_i,
	input wire logic cmd_done_i,
	output logic smb_clk_o,
	output logic cmd_valid_o,
	output temp_monitor_pkg::cmd_s cmd_o,
	output logic idle_o
);
	logic [1:0] tail;
	// link clock stands still between frames
	wire run = !resetn_i || start_i || !idle_o || tail != 2'd0;
	initial begin
		smb_clk_o = 1'b0;
		#5;
		forever #16 smb_clk_o = run ? ~smb_clk_o : 1'b0;
	end
	always @(posedge smb_clk_o or negedge resetn_i) begin
		if (!resetn_i) begin
			idle_o <= 1'b1;
			cmd_valid_o <= 1'b0;
			cmd_o <= '0;
			tail <= '0;
		end else if (!idle_o) begin
			if (cmd_busy_i) begin
				cmd_valid_o <= 1'b0;
				cmd_o <= ~cmd_o;
			end
			if (cmd_done_i) begin
				idle_o <= 1'b1;
				tail <= 2'd3;
			end
		end else if (start_i) begin
			cmd_valid_o <= 1'b1;
			cmd_o <= cmd_i;
			idle_o <= 1'b0;
		end else if (tail != 2'd0) begin
			tail <= tail - 2'd1;
		end
	end
endmodule : smb_host_model

// ### testbench/temp_monitor_conversion_control_tb_top.sv
`timescale 1ns/10ps
module temp_monitor_conversion_control_tb_top;
	import temp_monitor_pkg::*;
	logic core_clk_i = 0, resetn_i = 0, hw_sleep_n_i = 1, start = 0, idle;
	logic smb_clk_i, cmd_valid_i, cmd_busy_o, cmd_done_o, conv_busy_o, alert_n_o;
	cmd_s req = '0, cmd_i;
	reading_s reading_i = '{8'h19, 11'h02d};
	logic [7:0] rd_data_o, d;
	logic [8:0] e;
	logic [8:0] exp_q[$];
	logic [7:0] rst_v[6] = '{8'h00, 8'h02, 8'h7f, 8'hc9, 8'h7f, 8'hc9};
	logic [7:0] lim[4] = '{8'h19, 8'h80, 8'h06, 8'h05};
	int fails = 0, checked = 0, cyc = 0, t0 = 0;
	always #2 core_clk_i = ~core_clk_i;
	temp_monitor_conversion_control #(.MS_CYCLES(2)) dut (.core_clk_i, .resetn_i, .smb_clk_i,
		.cmd_valid_i, .cmd_i, .hw_sleep_n_i, .reading_i, .cmd_busy_o, .cmd_done_o, .rd_data_o,
		.conv_busy_o, .alert_n_o);
	smb_host_model host (.resetn_i, .start_i(start), .cmd_i(req), .cmd_busy_i(cmd_busy_o),
		.cmd_done_i(cmd_done_o), .smb_clk_o(smb_clk_i), .cmd_valid_o(cmd_valid_i),
		.cmd_o(cmd_i), .idle_o(idle));
	task automatic check(input logic [7:0] seen, input logic [7:0] want);
		checked++;
		if (seen !== want) begin
			fails++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, want);
		end
	endtask : check
	task automatic print_verdict();
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : print_verdict
	// bit 8 of an expectation marks a result that is not compared
	task automatic xfer(input logic w, input logic [7:0] c, input logic [7:0] v, input logic [8:0] x);
		exp_q.push_back(x);
		@(posedge core_clk_i) #1;
		req = '{w, c, v};
		start = 1;
		wait (idle === 1'b0);
		@(posedge core_clk_i) #1;
		start = 0;
		wait (idle === 1'b1);
		@(posedge core_clk_i) #1;
	endtask : xfer
	task automatic cyc_wait(input int n);
		repeat (n) @(posedge core_clk_i);
		#1;
	endtask : cyc_wait
	always @(posedge smb_clk_i) begin
		if (cmd_done_o === 1'b1 && exp_q.size() > 0) begin
			e = exp_q.pop_front();
			if (!e[8]) check(rd_data_o, e[7:0]);
		end
	end
	always @(posedge core_clk_i) begin
		cyc++;
		if (cyc == 50000) begin
			fails++;
			print_verdict();
		end
	end
	initial begin
		void'($urandom(62));
		repeat (8) @(posedge smb_clk_i);
		@(posedge core_clk_i) #1;
		resetn_i = 1;
		foreach (rst_v[i]) xfer(0, 8'h03 + 8'(i), 0, {1'b0, rst_v[i]});
		xfer(0, 8'h1f, 0, 9'h000);
		xfer(1, 8'h09, 8'h40, 9'h100);
		cyc_wait(20);
		wait (conv_busy_o === 1'b0);
		for (int i = 0; i < 4; i++) begin
			d = 8'($urandom);
			xfer(1, 8'h0b + 8'(i), d, 9'h100);
			xfer(0, 8'h05 + 8'(i), 0, {1'b0, d});
			xfer(1, 8'h0b + 8'(i), lim[i], 9'h100);
		end
		xfer(0, 8'h0f, 0, 9'h100);
		wait (conv_busy_o === 1'b1);
		wait (conv_busy_o === 1'b0);
		xfer(0, 8'h02, 0, 9'h048);
		xfer(0, 8'h01, 0, 9'h005);
		xfer(0, 8'h10, 0, 9'h000);
		xfer(0, 8'h00, 0, 9'h019);
		check({7'h0, alert_n_o}, 8'h00);
		xfer(1, 8'h09, 8'hc0, 9'h100);
		cyc_wait(10);
		check({7'h0, alert_n_o}, 8'h01);
		cyc_wait(10000);
		check({7'h0, conv_busy_o}, 8'h00);
		hw_sleep_n_i = 0;
		xfer(0, 8'h0f, 0, 9'h100);
		cyc_wait(20);
		check({7'h0, conv_busy_o}, 8'h00);
		xfer(0, 8'h02, 0, 9'h000);
		xfer(1, 8'h0a, 8'h04, 9'h100);
		hw_sleep_n_i = 1;
		xfer(1, 8'h09, 8'h00, 9'h100);
		cyc_wait(30);
		check({7'h0, conv_busy_o}, 8'h01);
		check({7'h0, alert_n_o}, 8'h00);
		xfer(0, 8'h02, 0, 9'h080);
		reading_i = '{8'h33, 11'h02d};
		hw_sleep_n_i = 0;
		cyc_wait(20);
		check({7'h0, conv_busy_o}, 8'h00);
		xfer(0, 8'h00, 0, 9'h019);
		hw_sleep_n_i = 1;
		wait (conv_busy_o === 1'b1);
		wait (conv_busy_o === 1'b0);
		xfer(0, 8'h10, 0, 9'h0a0);
		xfer(0, 8'h00, 0, 9'h033);
		xfer(0, 8'h0f, 0, 9'h100);
		t0 = cyc;
		check({7'h0, conv_busy_o}, 8'h01);
		cyc_wait(100);
		xfer(0, 8'h0f, 0, 9'h100);
		wait (conv_busy_o === 1'b0);
		check({7'h0, cyc - t0 < 250}, 8'h01);
		xfer(0, 8'h10, 0, 9'h000);
		check({7'h0, alert_n_o}, 8'h00);
		xfer(0, 8'h11, 0, 9'h100);
		check({7'h0, alert_n_o}, 8'h01);
		print_verdict();
	end
endmodule : temp_monitor_conversion_control_tb_top
